//--- snaplog_pkg.sv
/*
 Shared constants for the gated count snapshot logger: register offsets,
 command opcodes, reply kinds, flag layouts, reset values and timing.
 Assumes a 200 MHz single clock and an AXI4-Lite master for software.
*/
// Functional notes
// - With acknowledge-all mode on, every reply-less command answers OK or NG.
// - Turning acknowledge-all mode on always answers OK.
// - Unparsable command answers NG; OK only means processing proceeded.
// - With acknowledge-all mode off, reply-less commands give no reply.
// - Acknowledge mode query answers EN when on, DS when off.
// - Flag query on group 0..3 returns eight flag bits as hex.
// - Group 0 bits 0..3 carry overflow of counters 0..3.
// - Group 1 bits 0..2 carry overflow of counters 4..6.
// - Group 2 inputs, overflow 7, timer, counting, run-out; group 3 mode bits.
// - Gate mode counts while gate high, stores sample at each falling edge.
// - Gate-edge mode starts counting at first falling edge after start.
// - Gate-edge mode captures each sample at the following rising edge.
// - Host chooses both start and end sample address.
// - Set-pointer loads current address from argument 0..9999.
// - Acquisition halts once the current address reaches the end address.
// - Current address query returns the address in decimal.
// - End address query returns the programmed end address.
// - Pointer clear zeroes the current address, memory untouched.
// - Full clear zeroes pointer and memory, about 30 s, commands dropped meanwhile.
// - New samples overwrite whatever the current address holds.
// - Gate acquisition stores from current address up to end address.
// - Stop command ends any running acquisition at once.
package snaplog_pkg;
    localparam longint CLK_HZ     = 200_000_000;
    localparam longint CLR_TIME_S = 30;
    localparam longint CLR_CYC    = CLR_TIME_S * CLK_HZ;
    localparam int     DEPTH      = 10000;
    localparam logic [13:0] PTR_MAX = 14'h270F;
    localparam logic [15:0] ARG_MAX = 16'h270F;
    localparam logic [15:0] FLG_GROUPS = 16'h0004;

    localparam logic [7:0] OFS_CMD    = 8'h00;
    localparam logic [7:0] OFS_ARG    = 8'h04;
    localparam logic [7:0] OFS_REPLY  = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_MADDR  = 8'h10;
    localparam logic [7:0] OFS_MDATA  = 8'h14;

    localparam logic [7:0] OP_ACK_ON  = 8'h01;
    localparam logic [7:0] OP_ACK_OFF = 8'h02;
    localparam logic [7:0] OP_ACK_Q   = 8'h03;
    localparam logic [7:0] OP_FLAG_Q  = 8'h04;
    localparam logic [7:0] OP_PCLR    = 8'h05;
    localparam logic [7:0] OP_FCLR    = 8'h06;
    localparam logic [7:0] OP_SETCUR  = 8'h07;
    localparam logic [7:0] OP_CURQ    = 8'h08;
    localparam logic [7:0] OP_SETEND  = 8'h09;
    localparam logic [7:0] OP_ENDQ    = 8'h0A;
    localparam logic [7:0] OP_GSTART  = 8'h0B;
    localparam logic [7:0] OP_GESTART = 8'h0C;
    localparam logic [7:0] OP_STOP    = 8'h0D;
    localparam logic [7:0] OP_REVQ    = 8'h0E;

    localparam logic [3:0] RK_NONE = 4'h0;
    localparam logic [3:0] RK_OK   = 4'h1;
    localparam logic [3:0] RK_NG   = 4'h2;
    localparam logic [3:0] RK_EN   = 4'h3;
    localparam logic [3:0] RK_DS   = 4'h4;
    localparam logic [3:0] RK_HEX  = 4'h5;
    localparam logic [3:0] RK_DEC  = 4'h6;

    localparam int REP_VALID_BIT = 31;
    localparam int REP_KIND_LSB  = 24;
    localparam int ST_BUSY_BIT   = 16;
    localparam int ST_ACK_BIT    = 17;
    localparam int ST_RUN_BIT    = 18;

    localparam logic [13:0] RST_END = 14'h270F;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_GATE  = 5'h02,
        ST_EARM  = 5'h04,
        ST_ERUN  = 5'h08,
        ST_CLEAR = 5'h10
    } acq_state_e;
endpackage

//--- snaplog.sv
/*
 Gated count snapshot logger: command decoder with replies, flag groups,
 gate and gate-edge sample capture into a 10000-word memory, pointers.
 Assumes an AXI4-Lite master, counter values on count_in in this clock
 domain, and raw gate/start/stop pins from outside.
*/
module snaplog
    import snaplog_pkg::*;
#(
    parameter longint     CLEAR_CYCLES = CLR_CYC,
    parameter logic [7:0] HW_REV       = 8'h03 // Arbitrary revision value
) (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        gate_pin,
    input  wire logic        start_pin,
    input  wire logic        stop_pin,
    input  wire logic [7:0]  ovf_in,
    input  wire logic        tmr_ovf_in,
    input  wire logic [31:0] count_in,
    output logic             count_gate
);
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    logic [31:0] mem [0:DEPTH-1];
    acq_state_e  state_reg;
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        aw_full;
    logic        w_full;
    logic        wr_go;
    logic        cmd_go;
    logic        rd_reply;
    logic [15:0] arg_reg;
    logic [13:0] maddr_reg;
    logic        ack_mode_reg;
    logic        rep_valid_reg;
    logic [3:0]  rep_kind_reg;
    logic [15:0] rep_val_reg;
    logic [13:0] cur_reg;
    logic [13:0] end_reg;
    logic [13:0] cur_inc;
    logic        runout_reg;
    logic        count_gate_reg;
    logic [63:0] clr_cnt;
    logic [13:0] clr_addr;
    logic [2:0]  gate_sy;
    logic [1:0]  start_sy;
    logic [1:0]  stop_sy;
    logic        gate_fall;
    logic        gate_rise;
    logic        sample;
    logic        halt;
    logic [7:0]  cmd_op;
    logic        rep_set;
    logic [3:0]  rep_k;
    logic [15:0] rep_v;
    logic        silent;
    logic        good;
    logic        arg_ok;
    logic [7:0]  flag_byte;

    // Third gate stage only feeds the edge detectors, never the first stage
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gate_sy  <= 3'h0;
            start_sy <= 2'h0;
            stop_sy  <= 2'h0;
        end else begin
            gate_sy  <= {gate_sy[1:0], gate_pin};
            start_sy <= {start_sy[0], start_pin};
            stop_sy  <= {stop_sy[0], stop_pin};
        end
    end
    assign gate_fall = gate_sy[2] & ~gate_sy[1];
    assign gate_rise = ~gate_sy[2] & gate_sy[1];

    // Write channel: address and data taken in either order, answer after both
    assign wr_go = aw_full & w_full & ~s_axi_bvalid;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            awaddr_reg    <= 8'h00;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_reg    <= s_axi_awaddr;
                aw_full       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_reg    <= s_axi_wdata;
                wstrb_reg    <= s_axi_wstrb;
                w_full       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (hit(awaddr_reg, OFS_CMD) || hit(awaddr_reg, OFS_ARG) ||
                                 hit(awaddr_reg, OFS_MADDR)) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_full       <= 1'b0;
                w_full        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read channel; memory word is fetched in the same registered step
    assign rd_reply = s_axi_arvalid & s_axi_arready & hit(s_axi_araddr, OFS_REPLY);
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RESP_OKAY;
                s_axi_rdata   <= 32'h0000_0000;
                if (hit(s_axi_araddr, OFS_ARG)) begin
                    s_axi_rdata <= {16'h0000, arg_reg};
                end else if (hit(s_axi_araddr, OFS_REPLY)) begin
                    s_axi_rdata <= {rep_valid_reg, 3'h0, rep_kind_reg, 8'h00, rep_val_reg};
                end else if (hit(s_axi_araddr, OFS_STATUS)) begin
                    s_axi_rdata <= {13'h0000, count_gate_reg, ack_mode_reg,
                                    state_reg == ST_CLEAR, 2'h0, cur_reg};
                end else if (hit(s_axi_araddr, OFS_MADDR)) begin
                    s_axi_rdata <= {18'h00000, maddr_reg};
                end else if (hit(s_axi_araddr, OFS_MDATA)) begin
                    s_axi_rdata <= mem[maddr_reg];
                end else if (!hit(s_axi_araddr, OFS_CMD)) begin
                    s_axi_rresp <= RESP_SLVERR;
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Commands are dropped while the full clear runs: the bus still answers
    assign cmd_go = wr_go & hit(awaddr_reg, OFS_CMD) & wstrb_reg[0] & (state_reg != ST_CLEAR);
    assign cmd_op = wdata_reg[7:0];
    assign arg_ok = (arg_reg <= ARG_MAX);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            arg_reg   <= 16'h0000;
            maddr_reg <= 14'h0000;
        end else if (wr_go) begin
            if (hit(awaddr_reg, OFS_ARG)) begin
                arg_reg <= wdata_reg[15:0];
            end
            if (hit(awaddr_reg, OFS_MADDR)) begin
                maddr_reg <= wdata_reg[13:0];
            end
        end
    end

    always_comb begin
        flag_byte = 8'h00;
        case (arg_reg[1:0])
            2'h0: flag_byte = {4'h0, ovf_in[3:0]};
            2'h1: flag_byte = {5'h00, ovf_in[6:4]};
            2'h2: flag_byte = {1'b0, runout_reg, count_gate_reg, tmr_ovf_in, ovf_in[7],
                               gate_sy[1], stop_sy[1], start_sy[1]};
            default: flag_byte = {5'h00, state_reg == ST_EARM || state_reg == ST_ERUN,
                                  1'b0, state_reg == ST_GATE};
        endcase
    end

    always_comb begin
        rep_set = 1'b0;
        rep_k   = RK_NONE;
        rep_v   = 16'h0000;
        silent  = 1'b0;
        good    = 1'b1;
        case (cmd_op)
            OP_ACK_ON: begin
                rep_set = 1'b1;
                rep_k   = RK_OK;
            end
            OP_ACK_OFF, OP_PCLR, OP_FCLR, OP_GSTART, OP_GESTART, OP_STOP: begin
                silent = 1'b1;
            end
            OP_SETCUR, OP_SETEND: begin
                silent = 1'b1;
                good   = arg_ok;
            end
            OP_ACK_Q: begin
                rep_set = 1'b1;
                rep_k   = ack_mode_reg ? RK_EN : RK_DS;
            end
            OP_FLAG_Q: begin
                good    = (arg_reg < FLG_GROUPS);
                rep_set = 1'b1;
                rep_k   = RK_HEX;
                rep_v   = {8'h00, flag_byte};
            end
            OP_CURQ: begin
                rep_set = 1'b1;
                rep_k   = RK_DEC;
                rep_v   = {2'h0, cur_reg};
            end
            OP_ENDQ: begin
                rep_set = 1'b1;
                rep_k   = RK_DEC;
                rep_v   = {2'h0, end_reg};
            end
            OP_REVQ: begin
                rep_set = 1'b1;
                rep_k   = RK_DEC;
                rep_v   = {8'h00, HW_REV};
            end
            default: good = 1'b0;
        endcase
        if (!good) begin
            rep_set = !silent || ack_mode_reg;
            rep_k   = RK_NG;
            rep_v   = 16'h0000;
        end else if (silent) begin
            rep_set = ack_mode_reg;
            rep_k   = RK_OK;
        end
    end

    // A new reply wins over a read that clears the previous one
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rep_valid_reg <= 1'b0;
            rep_kind_reg  <= RK_NONE;
            rep_val_reg   <= 16'h0000;
        end else if (cmd_go && rep_set) begin
            rep_valid_reg <= 1'b1;
            rep_kind_reg  <= rep_k;
            rep_val_reg   <= rep_v;
        end else if (rd_reply) begin
            rep_valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ack_mode_reg <= 1'b0;
        end else if (cmd_go && cmd_op == OP_ACK_ON) begin
            ack_mode_reg <= 1'b1;
        end else if (cmd_go && cmd_op == OP_ACK_OFF) begin
            ack_mode_reg <= 1'b0;
        end
    end

    assign sample  = (state_reg == ST_GATE && gate_fall) || (state_reg == ST_ERUN && gate_rise);
    assign cur_inc = (cur_reg == PTR_MAX) ? PTR_MAX : cur_reg + 14'h0001;
    assign halt    = (cur_inc >= end_reg) || (cur_reg == PTR_MAX);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg      <= ST_IDLE;
            cur_reg        <= 14'h0000;
            end_reg        <= RST_END;
            runout_reg     <= 1'b0;
            count_gate_reg <= 1'b0;
            clr_cnt        <= 64'h0;
            clr_addr       <= 14'h0000;
        end else if (cmd_go && good && cmd_op == OP_STOP) begin
            state_reg      <= ST_IDLE;
            count_gate_reg <= 1'b0;
        end else if (cmd_go && good && cmd_op == OP_FCLR) begin
            state_reg      <= ST_CLEAR;
            cur_reg        <= 14'h0000;
            count_gate_reg <= 1'b0;
            clr_cnt        <= 64'h0;
            clr_addr       <= 14'h0000;
        end else if (cmd_go && good && cmd_op == OP_PCLR) begin
            cur_reg <= 14'h0000;
        end else if (cmd_go && good && cmd_op == OP_SETCUR) begin
            cur_reg <= arg_reg[13:0];
        end else if (cmd_go && good && cmd_op == OP_SETEND) begin
            end_reg <= arg_reg[13:0];
        end else if (cmd_go && good && cmd_op == OP_GSTART) begin
            state_reg  <= ST_GATE;
            runout_reg <= 1'b0;
        end else if (cmd_go && good && cmd_op == OP_GESTART) begin
            state_reg      <= ST_EARM;
            runout_reg     <= 1'b0;
            count_gate_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_GATE: count_gate_reg <= gate_sy[1];
                ST_EARM: begin
                    if (gate_fall) begin
                        state_reg      <= ST_ERUN;
                        count_gate_reg <= 1'b1;
                    end
                end
                ST_CLEAR: begin
                    // Long wait keeps the host locked out for the full clear time
                    clr_cnt <= clr_cnt + 64'h1;
                    if (clr_addr != PTR_MAX) begin
                        clr_addr <= clr_addr + 14'h0001;
                    end
                    if (clr_cnt >= 64'(CLEAR_CYCLES) - 64'h1) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: ;
            endcase
            if (sample) begin
                cur_reg <= cur_inc;
                if (halt) begin
                    state_reg      <= ST_IDLE;
                    runout_reg     <= 1'b1;
                    count_gate_reg <= 1'b0;
                end
            end
        end
    end
    assign count_gate = count_gate_reg;

    // Samples overwrite the word in place, no clear needed first
    always_ff @(posedge ref_clk) begin
        if (state_reg == ST_CLEAR) begin
            mem[clr_addr] <= 32'h0000_0000;
        end else if (sample) begin
            mem[cur_reg] <= count_in;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_fclr_go;
        cmd_go && cmd_op == OP_FCLR;
    endsequence
    sequence s_edge_open;
        state_reg == ST_EARM && gate_fall && !cmd_go;
    endsequence

    a_ack_all_reply: assert property (cmd_go && silent && ack_mode_reg |=> rep_valid_reg &&
        (rep_kind_reg == RK_OK || rep_kind_reg == RK_NG)) else $error("no ack in ack-all mode");
    a_ack_on_ok: assert property (cmd_go && cmd_op == OP_ACK_ON |=>
        rep_valid_reg && rep_kind_reg == RK_OK && ack_mode_reg) else $error("ack-on not answered OK");
    a_unknown_ng: assert property (cmd_go && !good && !silent |=> rep_kind_reg == RK_NG)
        else $error("bad command not NG");
    a_quiet_mode: assert property (cmd_go && silent && good && !ack_mode_reg |=>
        $stable(rep_kind_reg) && $stable(rep_val_reg)) else $error("reply in quiet mode");
    a_ack_query: assert property (cmd_go && cmd_op == OP_ACK_Q |=>
        rep_kind_reg == ($past(ack_mode_reg) ? RK_EN : RK_DS)) else $error("ack query wrong");
    a_gate_follow: assert property (state_reg == ST_GATE && !cmd_go && !sample |=>
        count_gate_reg == $past(gate_sy[1])) else $error("gate count enable wrong");
    a_edge_start: assert property (s_edge_open |=> state_reg == ST_ERUN && count_gate_reg)
        else $error("edge mode did not open");
    a_ptr_step: assert property (sample && !cmd_go |=> cur_reg == $past(cur_inc) &&
        $past(cur_inc) == $past(cur_reg) + 14'h0001 || $past(cur_reg) == PTR_MAX) else $error("pointer step");
    a_end_halt: assert property (sample && halt && !cmd_go |=> state_reg == ST_IDLE &&
        runout_reg && !count_gate_reg) else $error("no halt at end");
    a_ptr_clear: assert property (cmd_go && cmd_op == OP_PCLR |=> cur_reg == 14'h0000)
        else $error("pointer not cleared");
    a_stop_now: assert property (cmd_go && cmd_op == OP_STOP |=> state_reg == ST_IDLE &&
        !count_gate_reg) else $error("stop ignored");
    a_clear_hold: assert property (s_fclr_go |=> (state_reg == ST_CLEAR && !cmd_go) [*4])
        else $error("full clear not held");
endmodule

//--- pin_model.sv
/*
 Host-side pin model: gate pulse source and an external pulse counter.
 Assumes the logger's ref_clk and count_gate; start and stop levels set by the bench.
*/
module pin_model (
    input  wire logic  ref_clk,
    input  wire logic  count_gate,
    output logic       gate_pin,
    output logic       start_pin,
    output logic       stop_pin,
    output logic [31:0] count_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        gate_pin = 1'b0;
        start_pin = 1'b0;
        stop_pin = 1'b0;
        count_in = 32'h0;
    end
    // One input pulse counted per gate fall while the counter gate is open.
    // Spacing is far below the host minimum to keep runs short.
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            gate_pin <= 1'b1;
            repeat (20) @(posedge ref_clk);
            gate_pin <= 1'b0;
            if (count_gate) count_in <= count_in + 32'h1;
            repeat (19) @(posedge ref_clk);
        end
    endtask
    task automatic levels(input logic s, input logic p);
        start_pin <= s;
        stop_pin  <= p;
    endtask
endmodule

//--- tb.sv
/*
 Self-checking bench for the snapshot logger: AXI4-Lite commands, replies,
 flags, gate and gate-edge capture, pointers and clears.
 Assumes pin_model on the gate pins and a shortened full-clear time.
*/
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import snaplog_pkg::*;
    logic        ref_clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        gate_pin, start_pin, stop_pin, tmr_ovf_in, count_gate;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, ovf_in;
    logic [31:0] s_axi_wdata, s_axi_rdata, count_in, rep;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    int          n_mismatch = 0;
    int          total_checks = 0;
    snaplog #(.CLEAR_CYCLES(20000), .HW_REV(8'h5A)) i_snaplog (.ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gate_pin, .start_pin, .stop_pin, .ovf_in,
        .tmr_ovf_in, .count_in, .count_gate);
    pin_model i_pin_model (.ref_clk, .count_gate, .gate_pin, .start_pin, .stop_pin, .count_in);
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Reading the reply word also clears it, so every command is judged alone
    task automatic cmd(input logic [7:0] op, input logic [15:0] arg, input logic [3:0] kind,
                       input logic [15:0] val);
        wr(OFS_ARG, 32'(arg));
        wr(OFS_CMD, 32'(op));
        rd(OFS_REPLY, rep);
        if (kind == RK_NONE) begin
            chk("reply valid", 32'(rep[31]), 32'h0);
        end else begin
            chk("reply kind", 32'({rep[31], rep[27:24]}), 32'({1'b1, kind}));
        end
        if (kind == RK_HEX) chk("hex value", 32'(rep[7:0]), 32'(val[7:0]));
        if (kind == RK_DEC) chk("dec value", 32'(rep[15:0]), 32'(val));
    endtask
    task automatic mem_at(input logic [13:0] a, input logic [31:0] exp);
        wr(OFS_MADDR, 32'(a));
        rd(OFS_MDATA, rep);
        chk("memory word", rep, exp);
    endtask
    task automatic t_ack;
        cmd(OP_PCLR, 16'h0, RK_NONE, 16'h0);
        cmd(OP_ACK_Q, 16'h0, RK_DS, 16'h0);
        cmd(OP_ACK_ON, 16'h0, RK_OK, 16'h0);
        cmd(OP_PCLR, 16'h0, RK_OK, 16'h0);
        cmd(8'h7F, 16'h0, RK_NG, 16'h0);
        cmd(OP_SETCUR, 16'h2710, RK_NG, 16'h0);
        cmd(OP_ACK_Q, 16'h0, RK_EN, 16'h0);
        cmd(OP_REVQ, 16'h0, RK_DEC, 16'h5A);
        s_axi_wstrb <= 4'hE;
        cmd(OP_PCLR, 16'h0, RK_NONE, 16'h0);
        s_axi_wstrb <= 4'hF;
        cmd(OP_ACK_OFF, 16'h0, RK_OK, 16'h0);
    endtask
    task automatic t_flags;
        logic [7:0] fx [4] = '{8'h05, 8'h02, 8'h1B, 8'h00};
        @(posedge ref_clk);
        ovf_in <= 8'hA5;
        tmr_ovf_in <= 1'b1;
        i_pin_model.levels(1'b1, 1'b1);
        for (int g = 0; g < 4; g++) cmd(OP_FLAG_Q, 16'(g), RK_HEX, 16'(fx[g]));
        cmd(OP_FLAG_Q, 16'h4, RK_NG, 16'h0);
        ovf_in <= 8'h00;
        tmr_ovf_in <= 1'b0;
        i_pin_model.levels(1'b0, 1'b0);
    endtask
    task automatic t_gate;
        cmd(OP_SETCUR, 16'h5, RK_NONE, 16'h0);
        cmd(OP_SETEND, 16'h8, RK_NONE, 16'h0);
        cmd(OP_CURQ, 16'h0, RK_DEC, 16'h5);
        cmd(OP_ENDQ, 16'h0, RK_DEC, 16'h8);
        cmd(OP_GSTART, 16'h0, RK_NONE, 16'h0);
        cmd(OP_FLAG_Q, 16'h3, RK_HEX, 16'h01);
        i_pin_model.pulse(3);
        for (int k = 0; k < 3; k++) mem_at(14'(5 + k), 32'(k + 1));
        cmd(OP_CURQ, 16'h0, RK_DEC, 16'h8);
        cmd(OP_FLAG_Q, 16'h2, RK_HEX, 16'h40);
    endtask
    task automatic t_edge;
        cmd(OP_SETCUR, 16'h5, RK_NONE, 16'h0);
        cmd(OP_SETEND, 16'h7, RK_NONE, 16'h0);
        cmd(OP_GESTART, 16'h0, RK_NONE, 16'h0);
        cmd(OP_FLAG_Q, 16'h3, RK_HEX, 16'h04);
        rd(OFS_STATUS, rep);
        chk("gate before fall", 32'(rep[18]), 32'h0);
        i_pin_model.pulse(1);
        rd(OFS_STATUS, rep);
        chk("gate while low", 32'(rep[18]), 32'h1);
        chk("count gate pin", 32'(count_gate), 32'h1);
        i_pin_model.pulse(2);
        mem_at(14'h5, 32'h3);
        mem_at(14'h6, 32'h4);
        cmd(OP_CURQ, 16'h0, RK_DEC, 16'h7);
    endtask
    task automatic t_stop;
        cmd(OP_SETEND, 16'h64, RK_NONE, 16'h0);
        cmd(OP_GSTART, 16'h0, RK_NONE, 16'h0);
        i_pin_model.pulse(1);
        cmd(OP_CURQ, 16'h0, RK_DEC, 16'h8);
        cmd(OP_STOP, 16'h0, RK_NONE, 16'h0);
        i_pin_model.pulse(1);
        cmd(OP_CURQ, 16'h0, RK_DEC, 16'h8);
        rd(OFS_STATUS, rep);
        chk("gate after stop", 32'(rep[18]), 32'h0);
    endtask
    task automatic t_clear;
        cmd(OP_PCLR, 16'h0, RK_NONE, 16'h0);
        cmd(OP_CURQ, 16'h0, RK_DEC, 16'h0);
        mem_at(14'h5, 32'h3);
        cmd(OP_SETCUR, 16'h9, RK_NONE, 16'h0);
        wr(OFS_CMD, 32'(OP_FCLR));
        rd(OFS_STATUS, rep);
        chk("busy", 32'(rep[16]), 32'h1);
        for (int n = 0; n < 30000 && rep[16] !== 1'b0; n++) rd(OFS_STATUS, rep);
        chk("pointer after clear", 32'(rep[13:0]), 32'h0);
        mem_at(14'h5, 32'h0);
        rd(8'h40, rep);
        chk("unmapped read", 32'(resp), 32'(RESP_SLVERR));
        wr(8'h44, 32'h0);
        chk("unmapped write", 32'(resp), 32'(RESP_SLVERR));
    endtask
    initial begin
        nrst = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, tmr_ovf_in} = '0;
        {s_axi_awaddr, s_axi_araddr, ovf_in, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        t_ack;
        t_flags;
        t_gate;
        t_edge;
        t_stop;
        t_clear;
        wrap_up;
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        n_mismatch++;
        wrap_up;
    end
endmodule
